// file: bcd_ctrl_diag0.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01 - bits 31:24 read back the captured upstream bus number
// R02 - bits 23:19 read back the captured upstream device number
// R03 - capture bus and device from config writes to us
// R04 - bit 18 selects advisory nonfatal error reporting style
// R05 - bit 17 clear routes host wake into bridge; set blocks it
// R06 - bit 16 clear drives wake pin from host wake; set blocks it
// R07 - bits 15:14 hold maximum fifo depth setting
// R08 - bit 11 makes bridge answer any function number
// R09 - bit 10 returns all posted-write credits
// R10 - bit 8 returns all completion credits at once
// R11 - bit 7 selects cache-line-register sizing over side-band
// R12 - bit 6 picks four-line instead of two-line multiple-read prefetch
// R13 - four-line bit plus forced multiple read also covers plain reads
// R14 - prefetch disable forces one doubleword per burst read
// R15 - four-line prefetch only counts while line sizing is on
// R16 - bit 3 gates upstream acceptance on free buffer threshold
// R17 - bits 5:4 pick line plus 4, 8, 12 DW or two lines plus 4
// R18 - invalid cache line size is taken as eight doublewords
// R19 - bit 2 lets config requests reach memory-mapped registers
// R20 - bits 13:12, 9, 0 read zero, writes ignored
// R21 - software writes zero to bit 1, which resets to zero
// R22 - most fields reset only on fundamental reset
// R23 - wake-disable bits reset only on global or power-on reset
module bcd_ctrl_diag0
  import bcd_pkg::*;
#(
  parameter int FUNC_NUM = 0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fundamental_reset_n,
  input wire logic global_reset_n,
  input wire bcd_cfg_req_s cfg_req,
  output bcd_cfg_rsp_s cfg_rsp,
  input wire logic host_ctrl_wake,
  output logic bridge_wake_in,
  output logic host_ctrl_wake_pin,
  input wire logic [7:0] cache_line_size_dw,
  input wire logic force_multiple_read,
  input wire logic read_prefetch_disable,
  input wire logic up_read_multiple,
  input wire logic [7:0] up_free_space_dw,
  output logic up_accept_ok,
  output logic [3:0] prefetch_lines,
  output logic size_from_line_reg,
  output logic advisory_error_style_select,
  output logic config_any_function_enable,
  output logic posted_write_credit_return,
  output logic completion_credit_return,
  output logic cfg_mem_regs_enable,
  output logic [1:0] max_fifo_size
);

  // stored fields, one register per field
  logic [7:0] bus_num_ff;
  logic [4:0] dev_num_ff;
  logic alt_err_ff;
  logic wake_in_dis_ff;
  logic wake_pin_dis_ff;
  logic [1:0] fifo_size_ff;
  logic any_fn_ff;
  logic pw_cred_ff;
  logic cpl_cred_ff;
  logic line_size_sel_ff;
  logic pf4_ff;
  logic [1:0] thr_sel_ff;
  logic thr_en_ff;
  logic cfg_mem_ff;
  logic rsvd_rw_ff;

  // request decode and write merge
  logic fund_clr;
  logic glob_clr;
  logic fn_ok;
  logic reg_hit;
  logic reg_write;
  logic reg_read;
  logic cap_write;
  logic [31:0] bmask;
  logic [31:0] wr_mask;
  logic [31:0] reg_value;
  logic [31:0] nxt_ctrl;

  // prefetch and threshold helpers
  logic multiple_read;
  logic pf4_active;
  logic line_valid;
  logic [7:0] line_dw;
  logic [7:0] line_dw_x2;
  logic [7:0] thr_dw;

  // fundamental clear also follows the global one,
  // since the global reset pulls the fundamental one low
  assign fund_clr = rst || !fundamental_reset_n || !global_reset_n; // R22
  assign glob_clr = rst || !global_reset_n; // R23

  // decode of one configuration request
  assign fn_ok = any_fn_ff || (cfg_req.function_num == 3'(FUNC_NUM)); // R08
  assign reg_hit = cfg_req.valid && fn_ok && (cfg_req.offset == BCD_REG_OFFSET);
  assign reg_write = reg_hit && cfg_req.write;
  assign reg_read = reg_hit && !cfg_req.write;
  assign cap_write = cfg_req.valid && cfg_req.write && fn_ok; // R03

  // byte lanes to bit mask
  for (genvar gi = 0; gi < 4; gi++) begin : g_byte_mask
    assign bmask[gi*8 +: 8] = {8{cfg_req.byte_en[gi]}};
  end

  // read-only bits and reserved bits 13:12, 9 and 0 never take write data
  assign wr_mask = bmask & BCD_WRITE_MASK; // R20
  assign nxt_ctrl = (reg_value & ~wr_mask) | (cfg_req.wdata & wr_mask);

  // register image, reserved bits 13:12, 9 and 0 stay zero
  always_comb begin
    reg_value = BCD_RESET_VALUE;
    reg_value[BCD_BUS_MSB:BCD_BUS_LSB] = bus_num_ff; // R01
    reg_value[BCD_DEV_MSB:BCD_DEV_LSB] = dev_num_ff; // R02
    reg_value[BCD_ALT_ERR_BIT] = alt_err_ff;
    reg_value[BCD_WAKE_IN_DIS_BIT] = wake_in_dis_ff;
    reg_value[BCD_WAKE_PIN_DIS_BIT] = wake_pin_dis_ff;
    reg_value[BCD_FIFO_MSB:BCD_FIFO_LSB] = fifo_size_ff;
    reg_value[BCD_ANY_FN_BIT] = any_fn_ff;
    reg_value[BCD_PW_CRED_BIT] = pw_cred_ff;
    reg_value[BCD_CPL_CRED_BIT] = cpl_cred_ff;
    reg_value[BCD_LINE_CHECK_BIT] = line_size_sel_ff;
    reg_value[BCD_PF4_BIT] = pf4_ff;
    reg_value[BCD_THR_MSB:BCD_THR_LSB] = thr_sel_ff;
    reg_value[BCD_THR_EN_BIT] = thr_en_ff;
    reg_value[BCD_CFG_MEM_BIT] = cfg_mem_ff;
    reg_value[BCD_RSVD_RW_BIT] = rsvd_rw_ff;
  end

  // captured bus number, taken from any write routed to us,
  // whatever register that write is aimed at
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      bus_num_ff <= BCD_RESET_VALUE[BCD_BUS_MSB:BCD_BUS_LSB]; // R22
    end else if (cap_write) begin
      bus_num_ff <= cfg_req.route_bus; // R03
    end
  end

  // captured device number, same capture as the bus number
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      dev_num_ff <= BCD_RESET_VALUE[BCD_DEV_MSB:BCD_DEV_LSB]; // R22
    end else if (cap_write) begin
      dev_num_ff <= cfg_req.route_dev; // R03
    end
  end

  // error reporting style
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      alt_err_ff <= BCD_RESET_VALUE[BCD_ALT_ERR_BIT];
    end else if (reg_write) begin
      alt_err_ff <= nxt_ctrl[BCD_ALT_ERR_BIT]; // R04
    end
  end

  // wake input disable, survives a fundamental reset
  always_ff @(posedge clk) begin
    if (glob_clr) begin
      wake_in_dis_ff <= BCD_RESET_VALUE[BCD_WAKE_IN_DIS_BIT]; // R23
    end else if (reg_write) begin
      wake_in_dis_ff <= nxt_ctrl[BCD_WAKE_IN_DIS_BIT]; // R05
    end
  end

  // wake pin disable, survives a fundamental reset
  always_ff @(posedge clk) begin
    if (glob_clr) begin
      wake_pin_dis_ff <= BCD_RESET_VALUE[BCD_WAKE_PIN_DIS_BIT]; // R23
    end else if (reg_write) begin
      wake_pin_dis_ff <= nxt_ctrl[BCD_WAKE_PIN_DIS_BIT]; // R06
    end
  end

  // fifo depth setting
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      fifo_size_ff <= BCD_RESET_VALUE[BCD_FIFO_MSB:BCD_FIFO_LSB]; // R22
    end else if (reg_write) begin
      fifo_size_ff <= nxt_ctrl[BCD_FIFO_MSB:BCD_FIFO_LSB]; // R07
    end
  end

  // answer any function number
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      any_fn_ff <= BCD_RESET_VALUE[BCD_ANY_FN_BIT];
    end else if (reg_write) begin
      any_fn_ff <= nxt_ctrl[BCD_ANY_FN_BIT]; // R08
    end
  end

  // posted-write credit return
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      pw_cred_ff <= BCD_RESET_VALUE[BCD_PW_CRED_BIT];
    end else if (reg_write) begin
      pw_cred_ff <= nxt_ctrl[BCD_PW_CRED_BIT]; // R09
    end
  end

  // completion credit return
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      cpl_cred_ff <= BCD_RESET_VALUE[BCD_CPL_CRED_BIT];
    end else if (reg_write) begin
      cpl_cred_ff <= nxt_ctrl[BCD_CPL_CRED_BIT]; // R10
    end
  end

  // transaction sizing source
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      line_size_sel_ff <= BCD_RESET_VALUE[BCD_LINE_CHECK_BIT];
    end else if (reg_write) begin
      line_size_sel_ff <= nxt_ctrl[BCD_LINE_CHECK_BIT]; // R11
    end
  end

  // four-line prefetch enable
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      pf4_ff <= BCD_RESET_VALUE[BCD_PF4_BIT]; // R22
    end else if (reg_write) begin
      pf4_ff <= nxt_ctrl[BCD_PF4_BIT]; // R12
    end
  end

  // buffer threshold select
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      thr_sel_ff <= BCD_RESET_VALUE[BCD_THR_MSB:BCD_THR_LSB]; // R22
    end else if (reg_write) begin
      thr_sel_ff <= nxt_ctrl[BCD_THR_MSB:BCD_THR_LSB]; // R17
    end
  end

  // buffer threshold enable
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      thr_en_ff <= BCD_RESET_VALUE[BCD_THR_EN_BIT]; // R22
    end else if (reg_write) begin
      thr_en_ff <= nxt_ctrl[BCD_THR_EN_BIT]; // R16
    end
  end

  // config access to memory-mapped registers
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      cfg_mem_ff <= BCD_RESET_VALUE[BCD_CFG_MEM_BIT]; // R22
    end else if (reg_write) begin
      cfg_mem_ff <= nxt_ctrl[BCD_CFG_MEM_BIT]; // R19
    end
  end

  // reserved writable bit, kept as written
  always_ff @(posedge clk) begin
    if (fund_clr) begin
      rsvd_rw_ff <= BCD_RESET_VALUE[BCD_RSVD_RW_BIT]; // R22
    end else if (reg_write) begin
      rsvd_rw_ff <= nxt_ctrl[BCD_RSVD_RW_BIT];
    end
  end

  // registered answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.hit <= reg_hit;
      cfg_rsp.rdata <= reg_read ? reg_value : 32'h0000_0000; // R01 R02
    end
  end

  // field outputs
  assign bridge_wake_in = host_ctrl_wake && !wake_in_dis_ff; // R05
  assign host_ctrl_wake_pin = host_ctrl_wake && !wake_pin_dis_ff; // R06
  assign advisory_error_style_select = alt_err_ff; // R04
  assign max_fifo_size = fifo_size_ff; // R07
  assign config_any_function_enable = any_fn_ff; // R08
  assign posted_write_credit_return = pw_cred_ff; // R09
  assign completion_credit_return = cpl_cred_ff; // R10
  assign size_from_line_reg = line_size_sel_ff; // R11
  assign cfg_mem_regs_enable = cfg_mem_ff; // R19

  // prefetch depth selection
  assign multiple_read = up_read_multiple || force_multiple_read; // R13
  assign pf4_active = pf4_ff && line_size_sel_ff; // R15

  // disable wins over every other setting
  always_comb begin
    if (read_prefetch_disable) begin
      prefetch_lines = BCD_PF_ONE_DW; // R14
    end else if (pf4_active && multiple_read) begin
      prefetch_lines = BCD_PF_FOUR_LINES; // R12
    end else if (multiple_read) begin
      prefetch_lines = BCD_PF_TWO_LINES; // R12
    end else begin
      prefetch_lines = BCD_PF_ONE_LINE;
    end
  end

  // power of two, nonzero line sizes are valid
  assign line_valid = (cache_line_size_dw != 8'h00) &&
                      ((cache_line_size_dw & (cache_line_size_dw - 8'h01)) == 8'h00);
  assign line_dw = line_valid ? cache_line_size_dw : BCD_DEFAULT_LINE_DW; // R18
  assign line_dw_x2 = 8'(line_dw << 1);

  // free space needed before an upstream request is taken
  always_comb begin
    unique case (thr_sel_ff)
      2'h0: thr_dw = line_dw + BCD_THR_ADD_4; // R17
      2'h1: thr_dw = line_dw + BCD_THR_ADD_8;
      2'h2: thr_dw = line_dw + BCD_THR_ADD_12;
      2'h3: thr_dw = line_dw_x2 + BCD_THR_ADD_4;
    endcase
  end

  // upstream acceptance gate
  assign up_accept_ok = !thr_en_ff || (up_free_space_dw >= thr_dw); // R16

endmodule
`default_nettype wire

// file: bcd_pkg.sv
package bcd_pkg;

  localparam logic [7:0] BCD_REG_OFFSET = 8'hC0;
  localparam int BCD_BUS_MSB = 31;
  localparam int BCD_BUS_LSB = 24;
  localparam int BCD_DEV_MSB = 23;
  localparam int BCD_DEV_LSB = 19;
  localparam int BCD_ALT_ERR_BIT = 18;
  localparam int BCD_WAKE_IN_DIS_BIT = 17;
  localparam int BCD_WAKE_PIN_DIS_BIT = 16;
  localparam int BCD_FIFO_MSB = 15;
  localparam int BCD_FIFO_LSB = 14;
  localparam int BCD_ANY_FN_BIT = 11;
  localparam int BCD_PW_CRED_BIT = 10;
  localparam int BCD_CPL_CRED_BIT = 8;
  localparam int BCD_LINE_CHECK_BIT = 7;
  localparam int BCD_PF4_BIT = 6;
  localparam int BCD_THR_MSB = 5;
  localparam int BCD_THR_LSB = 4;
  localparam int BCD_THR_EN_BIT = 3;
  localparam int BCD_CFG_MEM_BIT = 2;
  localparam int BCD_RSVD_RW_BIT = 1;
  localparam logic [31:0] BCD_WRITE_MASK = 32'h0007_CDFE;
  localparam logic [31:0] BCD_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] BCD_FUND_MASK = 32'hFFF8_C07E;
  localparam logic [31:0] BCD_GLOBAL_MASK = 32'h0003_0000;
  localparam logic [7:0] BCD_DEFAULT_LINE_DW = 8'h08;
  localparam logic [7:0] BCD_THR_ADD_4 = 8'h04;
  localparam logic [7:0] BCD_THR_ADD_8 = 8'h08;
  localparam logic [7:0] BCD_THR_ADD_12 = 8'h0C;
  localparam logic [3:0] BCD_PF_ONE_DW = 4'h0;
  localparam logic [3:0] BCD_PF_ONE_LINE = 4'h1;
  localparam logic [3:0] BCD_PF_TWO_LINES = 4'h2;
  localparam logic [3:0] BCD_PF_FOUR_LINES = 4'h4;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [2:0] function_num;
    logic [7:0] route_bus;
    logic [4:0] route_dev;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } bcd_cfg_req_s;

  typedef struct packed {
    logic hit;
    logic [31:0] rdata;
  } bcd_cfg_rsp_s;

endpackage

// file: bcd_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_chk import bcd_pkg::*; #(parameter int FUNC_NUM = 0) (
  input wire logic clk,
  input wire logic rst,
  input wire bcd_cfg_req_s cfg_req,
  input wire bcd_cfg_rsp_s cfg_rsp,
  input wire logic host_ctrl_wake,
  input wire logic bridge_wake_in,
  input wire logic host_ctrl_wake_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_hit_after_take: assert property (cfg_req.valid && cfg_req.offset == 8'hC0 &&
    cfg_req.function_num == 3'(FUNC_NUM) |=> cfg_rsp.hit) else $error("no hit");
  chk_offset_refused: assert property (cfg_req.valid && cfg_req.offset != 8'hC0 |=> !cfg_rsp.hit)
    else $error("hit on other offset");
  chk_hit_cause: assert property (cfg_rsp.hit |-> $past(cfg_req.valid)) else $error("stray hit");
  chk_hit_single: assert property (cfg_rsp.hit && !cfg_req.valid |=> !cfg_rsp.hit) else $error("long hit");
  chk_idle_data: assert property (!cfg_rsp.hit |-> cfg_rsp.rdata == 32'h0) else $error("idle data");
  chk_rsvd_zero: assert property (cfg_rsp.hit |->
    {cfg_rsp.rdata[13:12], cfg_rsp.rdata[9], cfg_rsp.rdata[0]} == 4'h0) else $error("reserved set");
  chk_wake_input: assert property (bridge_wake_in |-> host_ctrl_wake) else $error("wake in");
  chk_wake_pin: assert property (host_ctrl_wake_pin |-> host_ctrl_wake) else $error("wake pin");
  cover property (cfg_rsp.hit);
  cover property (host_ctrl_wake && !host_ctrl_wake_pin);
  cover property (host_ctrl_wake && bridge_wake_in);
endmodule
bind bcd_ctrl_diag0 bcd_chk #(.FUNC_NUM(FUNC_NUM)) u_chk (.clk, .rst, .cfg_req, .cfg_rsp, .host_ctrl_wake,
  .bridge_wake_in, .host_ctrl_wake_pin);
`default_nettype wire

// file: bcd_host.sv
`timescale 1ns/1ps
`default_nettype none
module bcd_host import bcd_pkg::*; (
  input wire logic clk,
  output var bcd_cfg_req_s req,
  input wire bcd_cfg_rsp_s rsp
);
  initial req = '0;
  task automatic access(input logic w, input logic [2:0] f, input logic [7:0] o, input logic [31:0] d,
    output logic [31:0] r, output logic hit);
    @(negedge clk);
    req = '{1'b1, w, o, f, 8'h5A, 5'h13, 4'hF, d & 32'hFFFF_FFFD};
    @(negedge clk);
    req.valid = 1'b0;
    r = rsp.rdata;
    hit = rsp.hit;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bcd_pkg::*;
  logic clk = 0, rst = 1, fundamental_reset_n = 1, global_reset_n = 1, host_ctrl_wake = 1, h;
  logic force_multiple_read = 0, read_prefetch_disable = 0, up_read_multiple = 0, bridge_wake_in;
  logic host_ctrl_wake_pin, up_accept_ok, size_from_line_reg, advisory_error_style_select;
  logic config_any_function_enable, posted_write_credit_return, completion_credit_return, cfg_mem_regs_enable;
  logic [7:0] cache_line_size_dw = 8'h10, up_free_space_dw = 8'h00;
  logic [3:0] prefetch_lines;
  logic [1:0] max_fifo_size;
  logic [31:0] rd;
  bcd_cfg_req_s cfg_req;
  bcd_cfg_rsp_s cfg_rsp;
  int error_cnt = 0, comparisons = 0;
  bcd_ctrl_diag0 u_dut (.*);
  bcd_host u_host (.clk, .req(cfg_req), .rsp(cfg_rsp));
  initial forever #25 clk = ~clk;
  task automatic ck(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [2:0] f, input logic [7:0] o, input logic [31:0] d);
    u_host.access(w, f, o, d, rd, h);
  endtask
  task automatic rdc(input string n, input logic [31:0] e);
    acc(0, 0, 8'hC0, 0);
    ck(n, rd, e);
  endtask
  task automatic t_fields();
    rdc("reset", 0);
    acc(1, 0, 8'hC0, 32'hFFFF_FFFF);
    rdc("all", 32'h5A9F_CDFC);
    ck("ctl", 32'({advisory_error_style_select, config_any_function_enable, posted_write_credit_return,
      completion_credit_return, cfg_mem_regs_enable, max_fifo_size, size_from_line_reg}), 32'hFF);
    ck("wake", 32'({bridge_wake_in, host_ctrl_wake_pin}), 0);
    @(negedge clk) fundamental_reset_n = 0;
    @(negedge clk) fundamental_reset_n = 1;
    rdc("fund", 32'h0003_0000);
    @(negedge clk) {fundamental_reset_n, global_reset_n} = 2'h0;
    @(negedge clk) {fundamental_reset_n, global_reset_n} = 2'h3;
    rdc("glob", 0);
    ck("wake", 32'({bridge_wake_in, host_ctrl_wake_pin}), 3);
    acc(0, 1, 8'hC0, 0);
    ck("fn", 32'(h), 0);
    acc(0, 0, 8'hC4, 0);
    ck("offset", 32'(h), 0);
    acc(1, 0, 8'hC0, 32'h0000_0800);
    acc(0, 1, 8'hC0, 0);
    ck("any", 32'(h), 1);
  endtask
  task automatic pf(input logic [2:0] c, input logic [3:0] e);
    @(negedge clk) {up_read_multiple, force_multiple_read, read_prefetch_disable} = c;
    #1 ck("pf", 32'(prefetch_lines), 32'(e));
  endtask
  task automatic t_pf();
    acc(1, 0, 8'hC0, 32'h0000_00C0);
    pf(3'h4, 4'h4);
    pf(3'h2, 4'h4);
    pf(3'h5, 4'h0);
    acc(1, 0, 8'hC0, 32'h0000_0040);
    pf(3'h4, 4'h2);
  endtask
  task automatic thr(input logic [7:0] f, input logic e);
    @(negedge clk) up_free_space_dw = f;
    #1 ck("accept", 32'(up_accept_ok), 32'(e));
  endtask
  task automatic t_thr();
    logic [7:0] th [4] = '{8'h14, 8'h18, 8'h1C, 8'h24};
    for (int t = 0; t < 4; t++) begin
      acc(1, 0, 8'hC0, 32'(t * 16 + 8));
      thr(th[t] - 8'h1, 0);
      thr(th[t], 1);
    end
    cache_line_size_dw = 8'h03;
    thr(8'h13, 0);
    thr(8'h14, 1);
    acc(1, 0, 8'hC0, 0);
    thr(8'h00, 1);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_fields();
    t_pf();
    t_thr();
    print_verdict();
  end
  initial begin
    #20us;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
